// ### logic/dual_uart_host_map.svh
// Named offsets, indices and reset values of the dual channel host port
`ifndef DUAL_UART_HOST_MAP_SVH
`define DUAL_UART_HOST_MAP_SVH

`define CH_A           1'h0
`define CH_B           1'h1
`define NUM_CH         2
`define NUM_REGS       8
`define ALT_FUNC_INDEX 3'h7
`define ALT_FUNC_DUAL  0
`define BANK_RESET     8'h00
`define ALT_FUNC_RESET 8'h00
`define DOUT_RESET     8'h00
`define STROBE_IDLE    1'h1
`define FLAG_RESET     1'h0

`endif

// ### logic/dual_uart_host_pkg.sv
// Types shared by the dual channel host port
package dual_uart_host_pkg;

    typedef logic [7:0] byte_t;     // One register value
    typedef logic [2:0] index_t;    // Register index within a channel
    typedef logic [0:0] chan_t;     // Channel number, A is 0

    // One sample of the host bus pins
    typedef struct packed {
        logic   cs_n;
        logic   chan_select;
        index_t index;
        logic   rd_n;
        logic   wr_n;
        byte_t  wdata;
    } host_req_s;

endpackage

// ### logic/dual_uart_host_select_port.sv
// Host parallel port that routes register accesses to channel A or B
`timescale 1ns/1ps
`include "dual_uart_host_map.svh"

// How it works
// - Three-bit index picks register in channel
// - Select low means B, high means A
// - Override bit writes both channels at once
// - Transfers happen only while chip select low
// - Data bus driven only for read data
// - Read strobe fall loads register onto bus
// - Write strobe fall stores bus into register
// - Reset high clears registers, disables serial
module dual_uart_host_select_port (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        master_reset,
    input  wire logic        chip_select_n,
    input  wire logic        channel_select_pin,
    input  wire logic [2:0]  register_index,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             host_data_oe,
    output logic             serial_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and strobe edges

    dual_uart_host_pkg::host_req_s req;        // Bus pins as one bundle
    logic                          clear;      // Either reset source
    logic                          rd_fall;    // Read strobe falling, selected
    logic                          wr_fall;    // Write strobe falling, selected
    dual_uart_host_pkg::chan_t     sel_ch;     // Channel named by pin
    logic [`NUM_CH-1:0]            ch_wr;      // Per channel write enable
    dual_uart_host_pkg::byte_t     rd_value;   // Register picked for a read

    logic                          rd_prev_reg;
    logic                          rd_prev_next;
    logic                          wr_prev_reg;
    logic                          wr_prev_next;
    logic                          rd_active_reg;  // Read cycle in progress
    logic                          rd_active_next;
    logic                          ser_en_reg;     // Serial path allowed
    logic                          ser_en_next;
    dual_uart_host_pkg::byte_t     dout_reg;       // Read data latch
    dual_uart_host_pkg::byte_t     dout_next;
    dual_uart_host_pkg::byte_t     alt_func_reg;   // Alternate function
    dual_uart_host_pkg::byte_t     alt_func_next;
    dual_uart_host_pkg::byte_t     bank_reg  [`NUM_CH][`NUM_REGS];
    dual_uart_host_pkg::byte_t     bank_next [`NUM_CH][`NUM_REGS];

    assign req.cs_n        = chip_select_n;
    assign req.chan_select = channel_select_pin;
    assign req.index       = register_index;
    assign req.rd_n        = read_strobe_n;
    assign req.wr_n        = write_strobe_n;
    assign req.wdata       = host_data_in;

    // The reset pin of the part and the system reset act alike
    assign clear = !reset_n || master_reset;

    // Edges count only with chip select low; a strobe that falls
    // while deselected is ignored even if select drops later
    assign rd_fall = rd_prev_reg && !req.rd_n && !req.cs_n;
    assign wr_fall = wr_prev_reg && !req.wr_n && !req.cs_n;

    // Pin low selects B, high selects A
    assign sel_ch = req.chan_select ? `CH_A : `CH_B;

    ////////////////////////////////////////////////////////////////////////
    // Channel write enables

    // Override bit set broadcasts the write and ignores the pin
    generate
        for (genvar c = 0; c < `NUM_CH; c++) begin : g_chwr
            assign ch_wr[c] = wr_fall &&
                (alt_func_reg[`ALT_FUNC_DUAL] || (sel_ch == 1'(c)));
        end
    endgenerate

    // Read source never broadcasts: always the pin's own channel
    always_comb begin
        if (req.index == `ALT_FUNC_INDEX) begin
            rd_value = alt_func_reg;
        end else begin
            rd_value = bank_reg[sel_ch][req.index];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the strobe tracking and read latch

    always_comb begin
        rd_prev_next   = req.rd_n;
        wr_prev_next   = req.wr_n;
        ser_en_next    = 1'b1;
        dout_next      = dout_reg;
        rd_active_next = rd_active_reg;
        if (rd_fall) begin
            // Latch so the bus holds steady for the whole strobe
            dout_next      = rd_value;
            rd_active_next = 1'b1;
        end else if (req.rd_n || req.cs_n) begin
            // Strobe released or deselected ends the read
            rd_active_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the register banks

    always_comb begin
        alt_func_next = alt_func_reg;
        bank_next     = bank_reg;
        // Alternate function register is shared by both channels
        if (wr_fall && req.index == `ALT_FUNC_INDEX) begin
            alt_func_next = req.wdata;
        end
        for (int c = 0; c < `NUM_CH; c++) begin
            if (ch_wr[c] && req.index != `ALT_FUNC_INDEX) begin
                bank_next[c][req.index] = req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Strobes reset to idle high, so a strobe held low through
    // reset release counts as a fresh edge on the first cycle after
    always_ff @(posedge clk_sys) begin
        if (clear) begin
            rd_prev_reg   <= `STROBE_IDLE;
            wr_prev_reg   <= `STROBE_IDLE;
            rd_active_reg <= `FLAG_RESET;
            ser_en_reg    <= `FLAG_RESET;
            dout_reg      <= `DOUT_RESET;
            alt_func_reg  <= `ALT_FUNC_RESET;
        end else begin
            rd_prev_reg   <= rd_prev_next;
            wr_prev_reg   <= wr_prev_next;
            rd_active_reg <= rd_active_next;
            ser_en_reg    <= ser_en_next;
            dout_reg      <= dout_next;
            alt_func_reg  <= alt_func_next;
        end
    end

    // Bank storage, cleared with everything else
    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < `NUM_CH; c++) begin
            for (int r = 0; r < `NUM_REGS; r++) begin
                if (clear) begin
                    bank_reg[c][r] <= `BANK_RESET;
                end else begin
                    bank_reg[c][r] <= bank_next[c][r];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign host_data_out = dout_reg;
    // Drive only while the read is still held by the host
    assign host_data_oe  = rd_active_reg && !req.rd_n && !req.cs_n;
    assign serial_enable = ser_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (clear);

    a_read_data_load: assert property (
        rd_fall |=> host_data_out == $past(rd_value))
        else $error("read data not loaded on strobe fall");

    a_bus_drive_only: assert property (
        host_data_oe |-> (!chip_select_n && !read_strobe_n
            && $past(!chip_select_n) && $past(!read_strobe_n)))
        else $error("data bus driven outside a read");

    a_drive_after_fall: assert property (
        rd_fall ##1 (!read_strobe_n && !chip_select_n) |-> host_data_oe)
        else $error("read data not driven during strobe");

    a_write_chan_a: assert property (
        (wr_fall && channel_select_pin && !alt_func_reg[`ALT_FUNC_DUAL]
         && register_index != `ALT_FUNC_INDEX)
        |=> bank_reg[`CH_A][$past(register_index)] == $past(host_data_in))
        else $error("write to channel A lost");

    a_write_chan_b: assert property (
        (wr_fall && !channel_select_pin
         && register_index != `ALT_FUNC_INDEX)
        |=> bank_reg[`CH_B][$past(register_index)] == $past(host_data_in))
        else $error("write to channel B lost");

    a_dual_write_both: assert property (
        (wr_fall && alt_func_reg[`ALT_FUNC_DUAL]
         && register_index != `ALT_FUNC_INDEX)
        |=> (bank_reg[`CH_A][$past(register_index)] ==
             bank_reg[`CH_B][$past(register_index)]))
        else $error("override write did not reach both channels");

    a_deselect_quiet: assert property (
        chip_select_n |=> ($stable(alt_func_reg) && $stable(host_data_out)
                           && !host_data_oe))
        else $error("activity while chip deselected");

    a_read_single_b: assert property (
        (rd_fall && alt_func_reg[`ALT_FUNC_DUAL] && !channel_select_pin
         && register_index != `ALT_FUNC_INDEX)
        |=> host_data_out == $past(bank_reg[`CH_B][register_index]))
        else $error("override read not taken from channel B");

    a_reset_outputs: assert property (
        @(posedge clk_sys) disable iff (1'h0)
        clear |=> (!serial_enable && !host_data_oe
                   && host_data_out == `DOUT_RESET))
        else $error("outputs not cleared by reset");

endmodule

// ### testbench/host_cpu_model.sv
// External CPU model driving the host bus pins of the dual channel port
`timescale 1ns/1ps

module host_cpu_model (
    input  wire logic                         clk_sys,
    output dual_uart_host_pkg::host_req_s     req
);
    ////////////////////////////////////////////////////////////////////
    // Idle bus: deselected, both strobes high
    initial begin
        req = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 8'h5a};
    end

    ////////////////////////////////////////////////////////////////////
    // One access; strobe low two cycles, then a high gap before the next
    task automatic access(input logic wr, input logic cs_n,
                          input logic sel, input logic [2:0] idx,
                          input logic [7:0] d);
        @(negedge clk_sys);
        req.cs_n  = cs_n;
        req.chan_select = sel;
        req.index = idx;
        req.wdata = d;
        @(negedge clk_sys);
        if (wr) begin
            req.wr_n = 1'b0;
        end else begin
            req.rd_n = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        req.rd_n  = 1'b1;
        req.wr_n  = 1'b1;
        req.cs_n  = 1'b1;
        // Released bus must not keep showing the old byte
        req.wdata = ~d;
    endtask
endmodule

// ### testbench/dual_uart_host_select_port_test.sv
// Self-checking bench for the dual channel host select port
`timescale 1ns/1ps

module dual_uart_host_select_port_test;
    logic                          clk_sys;
    logic                          reset_n;
    logic                          master_reset;
    dual_uart_host_pkg::host_req_s req;
    logic [7:0]                    host_data_in;
    logic [7:0]                    host_data_out;
    logic                          host_data_oe;
    logic                          serial_enable;
    int                            num_errors = 0;
    int                            checks = 0;
    int                            cycles = 0;
    logic [7:0]                    bank [2][8];     // Reference banks
    logic [7:0]                    alt_func;        // Reference shared reg
    logic [7:0]                    exp_q [$];       // Expected read bytes
    logic [15:0]                   lfsr = 16'hb224; // Seed 45604
    logic                          oe_prev = 1'b0;

    // Wire level: device wins while it drives, else the CPU side
    assign host_data_in = host_data_oe ? host_data_out : req.wdata;

    ////////////////////////////////////////////////////////////////////
    // Clock and instances
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    host_cpu_model cpu_u (.clk_sys(clk_sys), .req(req));

    dual_uart_host_select_port dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .master_reset(master_reset), .chip_select_n(req.cs_n),
        .channel_select_pin(req.chan_select), .register_index(req.index),
        .read_strobe_n(req.rd_n), .write_strobe_n(req.wr_n),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .serial_enable(serial_enable));

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic clear_model();
        alt_func = 8'h00;
        for (int i = 0; i < 16; i++) bank[i/8][i%8] = 8'h00;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: byte %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    // Write, noting its effect; bank 0 is A (select high)
    task automatic wr(input logic cs_n, input logic sel,
                      input logic [2:0] idx, input logic [7:0] d);
        if (!cs_n && idx == 3'h7) alt_func = d;
        else if (!cs_n) for (int c = 0; c < 2; c++)
            if (alt_func[0] || c == int'(!sel)) bank[c][idx] = d;
        cpu_u.access(1'b1, cs_n, sel, idx, d);
    endtask

    // Read always from the selected bank only
    task automatic rd(input logic sel, input logic [2:0] idx);
        exp_q.push_back(idx == 3'h7 ? alt_func : bank[int'(!sel)][idx]);
        cpu_u.access(1'b0, 1'b0, sel, idx, 8'h00);
    endtask

    task automatic final_report();
        if (num_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Monitor: each new bus drive takes the oldest expected byte
    always @(posedge clk_sys) begin
        if (host_data_oe === 1'b1 && !oe_prev) begin
            if (exp_q.size() == 0) cmp_bit(1'b1, 1'b0);
            else cmp_byte(host_data_out, exp_q.pop_front());
        end
        if (req.rd_n || req.cs_n) cmp_bit(host_data_oe, 1'b0);
        oe_prev <= (host_data_oe === 1'b1);
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n = 1'b0;
        master_reset = 1'b0;
        clear_model();
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp_bit(serial_enable, 1'b1);
        for (int i = 0; i < 16; i++) rd(i[3], i[2:0]);
        for (int i = 0; i < 14; i++) wr(1'b0, i[0], i[3:1], rnd());
        for (int i = 0; i < 16; i++) rd(i[0], i[3:1]);
        wr(1'b1, 1'b1, 3'h2, rnd());
        cpu_u.access(1'b0, 1'b1, 1'b1, 3'h2, 8'h00);
        rd(1'b1, 3'h2);
        wr(1'b0, 1'b0, 3'h7, 8'h01);
        for (int i = 0; i < 7; i++) wr(1'b0, i[0], i[2:0], rnd());
        for (int i = 0; i < 16; i++) rd(i[0], i[3:1]);
        wr(1'b0, 1'b1, 3'h7, 8'h00);
        wr(1'b0, 1'b1, 3'h4, rnd());
        rd(1'b1, 3'h4);
        rd(1'b0, 3'h4);
        @(negedge clk_sys);
        master_reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        cmp_bit(serial_enable, 1'b0);
        master_reset = 1'b0;
        clear_model();
        rd(1'b1, 3'h4);
        rd(1'b0, 3'h7);
        repeat (4) @(negedge clk_sys);
        cmp_bit(exp_q.size() == 0, 1'b1);
        final_report();
    end
endmodule
